// [host_port_pkg.sv]
// host_port_pkg: shared constants and carrier types for the asynchronous host port
// assumes a 100 MHz internal clock; no other files are needed
package host_port_pkg;

   // =====================================================================
   // widths
   // =====================================================================
   localparam int unsigned ADDR_W    = 15;   // address lines one to fifteen
   localparam int unsigned BE_W      = 4;    // byte lane enables
   localparam int unsigned DATA_W    = 32;   // data bus width
   localparam int unsigned CNT_W     = 8;    // wait counter width

   // =====================================================================
   // address decode
   // =====================================================================
   localparam logic [ADDR_W-1:0] BANK_SEL_ADDR  = 15'h0007;  // bank select word
   localparam logic [ADDR_W-1:0] QUEUE_DAT_ADDR = 15'h0001;  // frame queue data word
   localparam logic [ADDR_W-1:0] ADDR_MASK      = 15'h7FFF;  // full decode

   // =====================================================================
   // timing, in ns, and derived cycle counts
   // =====================================================================
   localparam int unsigned CLK_PERIOD_NS     = 10;
   localparam int unsigned RD_WAIT_NORMAL_NS = 80;   // queue read, normal mode
   localparam int unsigned RD_WAIT_TURBO_NS  = 40;   // queue read, turbo mode
   localparam int unsigned WR_WAIT_QUEUE_NS  = 36;   // queue write wait
   localparam int unsigned WR_WAIT_TYP_NS    = 50;   // other write wait
   localparam int unsigned RD_WAIT_TYP_NS    = 40;   // other register read wait
   localparam int unsigned SYNC_STAGES       = 2;    // strobe synchroniser depth
   // least times round up to whole cycles
   localparam logic [CNT_W-1:0] RD_NORMAL_CYC =
      CNT_W'((RD_WAIT_NORMAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] RD_TURBO_CYC =
      CNT_W'((RD_WAIT_TURBO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] WR_QUEUE_CYC =
      CNT_W'((WR_WAIT_QUEUE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] WR_TYP_CYC =
      CNT_W'((WR_WAIT_TYP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] RD_TYP_CYC =
      CNT_W'((RD_WAIT_TYP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] ZERO_CYC = 8'h00;

   // =====================================================================
   // carrier types
   // =====================================================================
   typedef struct packed {
      logic [ADDR_W-1:0] addr;         // host_addr_bus
      logic              qual;         // addr_qualifier
      logic [BE_W-1:0]   be_n;         // byte_lane_enable_n
   } addr_group_t;

   typedef struct packed {
      logic              rd_n;         // read_strobe_n
      logic              wr_n;         // write_strobe_n
      logic              as_n;         // addr_strobe_n
      logic              ds_n;         // data_select_n
   } strobe_group_t;

   typedef enum logic [1:0] {
      TGT_OTHER,
      TGT_BANK,
      TGT_QUEUE
   } target_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RD_WAIT,
      ST_RD_HOLD,
      ST_WR_ACTIVE,
      ST_WR_POST
   } port_state_t;

endpackage

// [strobe_sync.sv]
// strobe_sync: two-flop synchroniser for the host strobe group
// assumes strobes idle high and arrive without relation to i_clk
`timescale 1ns/10ps
module strobe_sync
   import host_port_pkg::*;
(
   // clock and reset
   input  wire logic          i_clk,
   input  wire logic          i_resetn,
   // raw and synchronised strobes
   input  wire strobe_group_t i_raw,
   output strobe_group_t      o_sync
);

   // =====================================================================
   // two stages per bit; first stage read only by the second
   // =====================================================================
   strobe_group_t meta_q;     // first stage
   strobe_group_t sync_q;     // second stage

   // both stages reset to idle high
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         meta_q <= '1;
         sync_q <= '1;
      end else begin
         meta_q <= i_raw;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;

endmodule // strobe_sync

// [wait_timer.sv]
// wait_timer: loadable down counter that times host wait periods
// assumes a load pulse of one cycle; busy while more than one cycle is left
`timescale 1ns/10ps
module wait_timer
   import host_port_pkg::*;
(
   // clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_resetn,
   // load side
   input  wire logic             i_load,
   input  wire logic [CNT_W-1:0] i_count,
   // status
   output logic                  o_busy
);

   // =====================================================================
   // counter
   // =====================================================================
   logic [CNT_W-1:0] cnt_q;   // cycles still to wait
   logic [CNT_W-1:0] cnt_d;   // next count

   // load wins, else count down to zero
   assign cnt_d  = i_load ? i_count
                 : (cnt_q != ZERO_CYC) ? cnt_q - 8'h01 : cnt_q;
   // busy drops one cycle early so the registered ready rises on the edge
   // that ends the wait, giving exactly i_count ready-low cycles
   assign o_busy = (cnt_q > 8'h01);

   // counter register
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt_q <= ZERO_CYC;
      end else begin
         cnt_q <= cnt_d;
      end
   end

endmodule // wait_timer

// [async_host_port.sv]
// async_host_port: device end of the asynchronous parallel host interface
// assumes strobes are asynchronous and synchronised here; data pins two-way
`timescale 1ns/10ps
module async_host_port
   import host_port_pkg::*;
(
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_resetn,
   // host address group and strobes
   input  wire addr_group_t       i_addr,
   input  wire strobe_group_t     i_strobe,
   // mode straps
   input  wire logic              i_turbo,
   input  wire logic              i_use_addr_strobe,
   // host data pins, split into three signals
   input  wire logic [DATA_W-1:0] i_data,
   output logic      [DATA_W-1:0] o_data,
   output logic                   o_data_oe,
   // ready back to host
   output logic                   o_host_ready,
   // internal register side
   output logic                   o_reg_wr,
   output logic                   o_reg_rd,
   output addr_group_t            o_reg_addr,
   output logic      [DATA_W-1:0] o_reg_wdata,
   input  wire logic [DATA_W-1:0] i_reg_rdata
);

   // =====================================================================
   // strobe synchronisation
   // =====================================================================
   strobe_group_t sync_s;         // synchronised strobes
   strobe_group_t prev_q;         // previous synchronised strobes
   addr_group_t   addr_p1_q;      // address pins, first delay stage
   addr_group_t   addr_p2_q;      // address pins, in step with sync_s
   addr_group_t   latched_q;      // address in use for this access
   addr_group_t   latched_d;      // next latched address

   // all four strobes pass through two flops before use
   strobe_sync u_sync (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_raw    (i_strobe),
      .o_sync   (sync_s)
   );

   // previous value for edge detection
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         prev_q <= '1;
      end else begin
         prev_q <= sync_s;
      end
   end

   // address pins delayed in step with the strobe synchroniser, so the
   // value present at the raw strobe rise is the one that gets latched
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         addr_p1_q <= '0;
         addr_p2_q <= '0;
      end else begin
         addr_p1_q <= i_addr;
         addr_p2_q <= addr_p1_q;
      end
   end

   // =====================================================================
   // edge decode
   // =====================================================================
   logic sel_ok;                  // selected by qualifier or data select
   logic rd_fall;                 // read strobe asserted
   logic rd_rise;                 // read strobe released
   logic wr_fall;                 // write strobe asserted
   logic wr_rise;                 // write strobe released
   logic as_rise;                 // address strobe released

   assign sel_ok  = latched_q.qual | ~sync_s.ds_n;
   assign rd_fall = prev_q.rd_n & ~sync_s.rd_n;
   assign rd_rise = ~prev_q.rd_n & sync_s.rd_n;
   assign wr_fall = prev_q.wr_n & ~sync_s.wr_n;
   assign wr_rise = ~prev_q.wr_n & sync_s.wr_n;
   assign as_rise = ~prev_q.as_n & sync_s.as_n;

   // =====================================================================
   // address latch
   // =====================================================================
   // strobe mode holds the value from the strobe rise; else follow pins
   assign latched_d = i_use_addr_strobe ? (as_rise ? addr_p2_q : latched_q)
                                        : i_addr;

   // address latch register
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         latched_q <= '0;
      end else begin
         latched_q <= latched_d;
      end
   end

   // =====================================================================
   // target decode and wait selection
   // =====================================================================
   target_t          tgt;         // which register is addressed
   logic [CNT_W-1:0] rd_wait;     // read wait in cycles
   logic [CNT_W-1:0] wr_wait;     // write wait in cycles

   assign tgt = ((latched_q.addr & ADDR_MASK) == BANK_SEL_ADDR)  ? TGT_BANK
              : ((latched_q.addr & ADDR_MASK) == QUEUE_DAT_ADDR) ? TGT_QUEUE
              : TGT_OTHER;

   // bank select reads free; queue reads by mode
   assign rd_wait = (tgt == TGT_BANK)  ? ZERO_CYC
                  : (tgt == TGT_QUEUE) ? (i_turbo ? RD_TURBO_CYC
                                                  : RD_NORMAL_CYC)
                  : RD_TYP_CYC;
   // bank select writes free; queue writes short
   assign wr_wait = (tgt == TGT_BANK)  ? ZERO_CYC
                  : (tgt == TGT_QUEUE) ? WR_QUEUE_CYC
                  : WR_TYP_CYC;

   // =====================================================================
   // control state machine
   // =====================================================================
   port_state_t state_q;          // current state
   port_state_t state_d;          // next state
   logic        tmr_load;         // start the wait timer
   logic [CNT_W-1:0] tmr_count;   // count to load
   logic        tmr_busy;         // wait still running
   logic        rdy_d;            // next ready value
   logic        rdy_q;            // ready register

   wait_timer u_timer (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_load   (tmr_load),
      .i_count  (tmr_count),
      .o_busy   (tmr_busy)
   );

   // next state, timer load and ready
   always_comb begin
      state_d   = state_q;
      tmr_load  = 1'b0;
      tmr_count = ZERO_CYC;
      rdy_d     = rdy_q;
      case (state_q)
         ST_IDLE, ST_WR_POST: begin
            // posted write finishing; a new access may still begin
            if (state_q == ST_WR_POST && !tmr_busy) begin
               rdy_d   = 1'b1;
               state_d = ST_IDLE;
            end
            if (rd_fall && sel_ok) begin
               // read starts; host may do so while ready still low
               tmr_load  = 1'b1;
               tmr_count = rd_wait;
               rdy_d     = (rd_wait == ZERO_CYC);
               state_d   = (rd_wait == ZERO_CYC) ? ST_RD_HOLD : ST_RD_WAIT;
            end else if (wr_fall && sel_ok) begin
               state_d = ST_WR_ACTIVE;
            end
         end
         ST_RD_WAIT: begin
            // hold ready low until the wait ends; host holds strobe
            if (!tmr_busy) begin
               rdy_d   = 1'b1;
               state_d = ST_RD_HOLD;
            end
         end
         ST_RD_HOLD: begin
            // data stays driven until strobe release
            if (rd_rise) begin
               state_d = ST_IDLE;
            end
         end
         ST_WR_ACTIVE: begin
            // strobe release posts the write and drops ready unless the wait is zero
            if (wr_rise) begin
               tmr_load  = 1'b1;
               tmr_count = wr_wait;
               rdy_d     = (wr_wait == ZERO_CYC);
               state_d   = (wr_wait == ZERO_CYC) ? ST_IDLE : ST_WR_POST;
            end
         end
         default: begin
            state_d = ST_IDLE;
            rdy_d   = 1'b1;
         end
      endcase
   end

   // state and ready registers
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_q <= ST_IDLE;
         rdy_q   <= 1'b1;
      end else begin
         state_q <= state_d;
         rdy_q   <= rdy_d;
      end
   end

   assign o_host_ready = rdy_q;

   // =====================================================================
   // data path
   // =====================================================================
   logic [DATA_W-1:0] rdata_q;    // read data to host
   logic [DATA_W-1:0] wdata_q;    // captured write data
   logic [DATA_W-1:0] wdata_d;    // next write data
   logic              oe_q;       // data pins driven
   logic              oe_d;       // next drive enable
   logic              wr_q;       // internal write pulse
   logic              rd_q;       // internal read pulse
   logic              rd_go;      // read accepted this cycle
   logic              wr_go;      // write posted this cycle
   logic              rd_load;    // sample register read data

   assign rd_go   = (state_q == ST_IDLE || state_q == ST_WR_POST) && rd_fall && sel_ok;
   assign wr_go   = (state_q == ST_WR_ACTIVE) && wr_rise;
   // read data sampled as ready returns high
   assign rd_load = (rdy_d && !rdy_q && state_q == ST_RD_WAIT)
                  || (rd_go && rd_wait == ZERO_CYC);
   // write data taken at strobe release
   assign wdata_d = wr_go ? i_data : wdata_q;
   // drive from read start to strobe release
   assign oe_d    = rd_go ? 1'b1 : ((state_q == ST_RD_HOLD && rd_rise) ? 1'b0 : oe_q);

   // data registers
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rdata_q <= '0;
         wdata_q <= '0;
         oe_q    <= 1'b0;
         wr_q    <= 1'b0;
         rd_q    <= 1'b0;
      end else begin
         rdata_q <= rd_load ? i_reg_rdata : rdata_q;
         wdata_q <= wdata_d;
         oe_q    <= oe_d;
         wr_q    <= wr_go;
         rd_q    <= rd_go;
      end
   end

   assign o_data      = rdata_q;
   assign o_data_oe   = oe_q;
   assign o_reg_wr    = wr_q;
   assign o_reg_rd    = rd_q;
   assign o_reg_addr  = latched_q;
   assign o_reg_wdata = wdata_q;

   // =====================================================================
   // assertions
   // =====================================================================
   sequence s_rd_start;
      rd_go;
   endsequence

   property p_rd_ready_low;
      @(posedge i_clk) disable iff (!i_resetn)
      (s_rd_start and (rd_wait != ZERO_CYC)) |=> !o_host_ready;
   endproperty
   a_rd_ready_low: assert property (p_rd_ready_low) else $error("ready not low on read");

   property p_wr_ready_low;
      @(posedge i_clk) disable iff (!i_resetn)
      wr_go && (wr_wait != ZERO_CYC) |=> !o_host_ready;
   endproperty
   a_wr_ready_low: assert property (p_wr_ready_low) else $error("ready not low after write");

   property p_bank_rd;
      @(posedge i_clk) disable iff (!i_resetn)
      rd_go && tgt == TGT_BANK |=> o_host_ready;
   endproperty
   a_bank_rd: assert property (p_bank_rd) else $error("bank read waited");

   property p_bank_wr;
      @(posedge i_clk) disable iff (!i_resetn)
      wr_go && tgt == TGT_BANK |=> o_host_ready;
   endproperty
   a_bank_wr: assert property (p_bank_wr) else $error("bank write waited");

   property p_q_normal;
      @(posedge i_clk) disable iff (!i_resetn)
      rd_go && tgt == TGT_QUEUE && !i_turbo |=> !o_host_ready [*8] ##1 o_host_ready;
   endproperty
   a_q_normal: assert property (p_q_normal) else $error("normal queue wait wrong");

   property p_q_turbo;
      @(posedge i_clk) disable iff (!i_resetn)
      rd_go && tgt == TGT_QUEUE && i_turbo |=> !o_host_ready [*4] ##1 o_host_ready;
   endproperty
   a_q_turbo: assert property (p_q_turbo) else $error("turbo queue wait wrong");

   property p_q_write;
      @(posedge i_clk) disable iff (!i_resetn)
      wr_go && tgt == TGT_QUEUE |=> !o_host_ready [*4] ##1 o_host_ready;
   endproperty
   a_q_write: assert property (p_q_write) else $error("queue write wait wrong");

   property p_rd_data;
      @(posedge i_clk) disable iff (!i_resetn)
      $rose(o_host_ready) && state_q == ST_RD_HOLD |-> o_data_oe && o_data == $past(i_reg_rdata);
   endproperty
   a_rd_data: assert property (p_rd_data) else $error("read data not valid at ready");

   property p_wr_capture;
      @(posedge i_clk) disable iff (!i_resetn)
      wr_go |=> o_reg_wr && o_reg_wdata == $past(i_data);
   endproperty
   a_wr_capture: assert property (p_wr_capture) else $error("write data not captured");

   property p_addr_latch;
      @(posedge i_clk) disable iff (!i_resetn)
      i_use_addr_strobe && as_rise |=> o_reg_addr == $past(i_addr, 3);
   endproperty
   a_addr_latch: assert property (p_addr_latch) else $error("address not latched");

endmodule // async_host_port

// [host_model.sv]
// host_model: bus-cycle model of the host processor on the port pins
// assumes i_clk is the device clock; every pin change lands on its rising edge
`timescale 1ns/10ps
module host_model
   import host_port_pkg::*;
(
   // clock and device answers
   input  wire logic              i_clk,
   input  wire logic              i_ready,
   input  wire logic [DATA_W-1:0] i_rdata,
   // host pins
   output addr_group_t            o_addr,
   output strobe_group_t          o_strobe,
   output logic      [DATA_W-1:0] o_wdata
);
   // idle pins at time zero
   initial begin
      o_addr   = '0;
      o_strobe = 4'hF;
      o_wdata  = '0;
   end

   // =====================================================================
   // released lines show the inverse, never the last value
   // =====================================================================
   task automatic release_lines(input addr_group_t a, input logic [DATA_W-1:0] d);
      o_addr        <= ~a;
      o_wdata       <= ~d;
      o_strobe.ds_n <= 1'b1;
   endtask

   // =====================================================================
   // one access; lows counts ready-low cycles seen after the strobe
   // =====================================================================
   task automatic access(input logic wr, input logic as, input logic ds,
                         input logic chain, input addr_group_t a,
                         input logic [DATA_W-1:0] d, output int lows,
                         output logic [DATA_W-1:0] q);
      int i;
      lows = 0;
      q    = '0;
      @(posedge i_clk);
      o_addr        <= a;
      o_strobe.as_n <= 1'b0;
      o_strobe.ds_n <= ~ds;
      o_wdata       <= d;
      @(posedge i_clk);
      // address strobe mode: latch, then the lines move on
      if (as) begin
         o_strobe.as_n <= 1'b1;
         @(posedge i_clk);
         o_addr <= ~a;
      end
      if (wr) begin
         o_strobe.wr_n <= 1'b0;
         repeat (2 + $urandom_range(2)) @(posedge i_clk);
         o_strobe.wr_n <= 1'b1;
         // chained: leave while ready is still low
         for (i = 0; i < (chain ? 5 : 16); i++) begin
            @(posedge i_clk);
            if (i == 4) release_lines(a, d);
            #1 lows += int'(!i_ready);
         end
      end else begin
         o_strobe.rd_n <= 1'b0;
         // strobe held low until ready is high again
         for (i = 0; i < 30; i++) begin
            @(posedge i_clk);
            #1 lows += int'(!i_ready);
            if (i_ready && i >= 8) break;
         end
         q = i_rdata;
         @(posedge i_clk);
         o_strobe.rd_n <= 1'b1;
         release_lines(a, d);
      end
   endtask
endmodule // host_model

// [test_async_host_bus_wait_handshake.sv]
// test_async_host_bus_wait_handshake: self-checking bench of the host port
// assumes host_model on the pins and a bench register file behind the port
`timescale 1ns/10ps
module test_async_host_bus_wait_handshake
   import host_port_pkg::*;
;
   // =====================================================================
   // wiring and bench state
   // =====================================================================
   logic              clk, resetn, turbo, use_as, oe, ready, reg_wr, reg_rd;
   addr_group_t       h_addr, reg_addr, wr_addr;
   strobe_group_t     h_strobe;
   logic [DATA_W-1:0] h_wdata, bus_data, rdata, reg_wdata, reg_rdata, key, wr_data;
   logic [ADDR_W-1:0] tgt [3];
   int                num_errors = 0, check_count = 0, wr_seen = 0, rd_seen = 0;

   // clock, 10 ns period
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // data pins resolved from both drivers
   assign bus_data  = oe ? rdata : h_wdata;
   // register file: word depends on the latched address
   assign reg_rdata = DATA_W'(reg_addr.addr) ^ key;

   async_host_port i_dut (
      .i_clk(clk), .i_resetn(resetn), .i_addr(h_addr), .i_strobe(h_strobe),
      .i_turbo(turbo), .i_use_addr_strobe(use_as), .i_data(bus_data),
      .o_data(rdata), .o_data_oe(oe), .o_host_ready(ready), .o_reg_wr(reg_wr),
      .o_reg_rd(reg_rd), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata),
      .i_reg_rdata(reg_rdata));

   host_model i_host (
      .i_clk(clk), .i_ready(ready), .i_rdata(bus_data),
      .o_addr(h_addr), .o_strobe(h_strobe), .o_wdata(h_wdata));

   // register-side monitor: pulses and captured write
   always @(posedge clk) begin
      if (reg_wr) begin
         wr_seen++;
         wr_data = reg_wdata;
         wr_addr = reg_addr;
      end
      if (reg_rd) rd_seen++;
   end

   // =====================================================================
   // helpers
   // =====================================================================
   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // expected ready-low cycles for a target
   function automatic int exp_wait(input logic wr, input logic [ADDR_W-1:0] ad,
                                   input logic tb);
      if (ad == BANK_SEL_ADDR) return 0;
      if (ad == QUEUE_DAT_ADDR)
         return wr ? int'(WR_QUEUE_CYC) : (tb ? int'(RD_TURBO_CYC) : int'(RD_NORMAL_CYC));
      return wr ? int'(WR_TYP_CYC) : int'(RD_TYP_CYC);
   endfunction

   // one access; mode 0 plain, 1 address strobe, 2 data select, 3 unselected
   task automatic op(input logic wr, input int mode, input logic [ADDR_W-1:0] ad,
                     input logic tb, input logic chain, input logic cw);
      addr_group_t       a;
      logic [DATA_W-1:0] d, q;
      int                lows, w0, r0;
      a.addr = ad;
      a.qual = (mode < 2);
      a.be_n = BE_W'($urandom);
      d      = $urandom;
      w0     = wr_seen;
      r0     = rd_seen;
      @(posedge clk);
      turbo  <= tb;
      use_as <= (mode == 1);
      i_host.access(wr, mode == 1, mode == 2, chain, a, d, lows, q);
      if (cw) check(DATA_W'(lows), DATA_W'(mode == 3 ? 0 : exp_wait(wr, ad, tb)));
      if (mode == 3) begin
         check(DATA_W'(wr_seen + rd_seen - w0 - r0), '0);
      end else if (wr) begin
         check(DATA_W'(wr_seen - w0), 1);
         check(wr_data, d);
         check(DATA_W'(wr_addr), DATA_W'(a));
      end else begin
         check(DATA_W'(rd_seen - r0), 1);
         check(q, DATA_W'(ad) ^ key);
      end
   endtask

   task automatic final_report;
      $display("checks=%0d errors=%0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // =====================================================================
   // main sequence
   // =====================================================================
   initial begin
      void'($urandom(32'hd2c4_67c3));
      resetn = 1'b0;
      turbo  = 1'b0;
      use_as = 1'b0;
      key    = '0;
      tgt    = '{BANK_SEL_ADDR, QUEUE_DAT_ADDR, 15'h0123};
      repeat (16) @(posedge clk);
      #1 check(DATA_W'(ready), 1);
      check(DATA_W'(oe), 0);
      @(posedge clk);
      resetn <= 1'b1;
      key = $urandom;
      $display("test reset done");
      // modes 0 to 2 against every target, both directions
      for (int m = 0; m < 3; m++) begin
         for (int t = 0; t < 3; t++) begin
            op(1'b0, m, tgt[t], m[0], 1'b0, 1'b1);
            op(1'b1, m, tgt[t], 1'b0, 1'b0, 1'b1);
         end
      end
      $display("test mode table done");
      // unselected accesses are ignored
      op(1'b0, 3, QUEUE_DAT_ADDR, 1'b0, 1'b0, 1'b1);
      op(1'b1, 3, QUEUE_DAT_ADDR, 1'b0, 1'b0, 1'b1);
      $display("test unselected done");
      // read issued just after a write that the host left while ready was still low
      op(1'b1, 0, QUEUE_DAT_ADDR, 1'b0, 1'b1, 1'b0);
      op(1'b0, 0, QUEUE_DAT_ADDR, 1'b0, 1'b0, 1'b0);
      $display("test back to back done");
      // random traffic, random addresses
      for (int n = 0; n < 30; n++) begin
         logic [ADDR_W-1:0] ad;
         ad = ADDR_W'($urandom);
         if (ad[0]) ad = tgt[$urandom_range(2)];
         op(1'($urandom), $urandom_range(3), ad, 1'($urandom), 1'b0, 1'b1);
      end
      $display("test random done");
      final_report();
   end

   // watchdog: about twenty times the expected run length
   initial begin
      #200_000;
      num_errors++;
      final_report();
   end
endmodule // test_async_host_bus_wait_handshake
